// >>> bench/host_model.sv
// Host processor model that drives the parallel bus of the timer block.
module host_model (
    input  wire logic       clk_i,
    output logic            cs_b_o,
    output logic            rd_b_o,
    output logic            wr_b_o,
    output logic [1:0]      port_o,
    output logic [7:0]      wd_o,
    input  wire logic [7:0] rd_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cs_b_o, rd_b_o, wr_b_o, port_o, wd_o} = {3'h7, 2'h0, 8'hff};
    // Strobes stand two cycles and one idle cycle follows each access.
    // Callers keep two-byte accesses of one channel unbroken.
    task automatic wr(input logic [1:0] p, input logic [7:0] d);
        @(posedge clk_i);
        {cs_b_o, wr_b_o, port_o, wd_o} <= {2'h0, p, d};
        repeat (2) @(posedge clk_i);
        {cs_b_o, wr_b_o, wd_o} <= {2'h3, ~d}; // Released data shows no stale value.
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [1:0] p, output logic [7:0] d);
        @(posedge clk_i);
        {cs_b_o, rd_b_o, port_o} <= {2'h0, p};
        repeat (2) @(posedge clk_i);
        d = rd_i;
        {cs_b_o, rd_b_o} <= 2'h3;
        @(posedge clk_i);
    endtask
endmodule

// >>> bench/interval_timer_program_readout_sva.sv
// Port-level checks of the timer programming and readout block.
module interval_timer_program_readout_sva
    import pit_pkg::*;
(
    input wire logic                         clk_sys_i,
    input wire logic                         rst_b_i,
    input wire logic                         chip_sel_b_i,
    input wire logic                         rd_b_i,
    input wire logic                         wr_b_i,
    input wire logic                         port_sel_hi_i,
    input wire logic                         port_sel_lo_i,
    input wire logic [7:0]                   data_i,
    input wire logic [7:0]                   data_o,
    input wire logic                         data_oe_o,
    input wire logic [pit_pkg::CHANNELS-1:0] preset_ready_o,
    input wire logic [pit_pkg::CHANNELS-1:0] setup_written_o,
    input wire logic [2:0]                   op_mode_o [pit_pkg::CHANNELS]
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic       prev_act;
    wire        wr_act  = !chip_sel_b_i && !wr_b_i && rd_b_i;
    wire        wr_take = wr_act && !prev_act;
    wire [1:0]  port    = {port_sel_hi_i, port_sel_lo_i};
    wire        setup_w = wr_take && port == PORT_SETUP;
    // Only the first active cycle of a long write strobe counts as the write.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) prev_act <= 1'b0;
        else prev_act <= wr_act;
    end
    a_oe_after_read: assert property (data_oe_o |-> $past(!chip_sel_b_i && !rd_b_i))
        else $error("read data driven without a read strobe");
    a_oe_drops: assert property ($rose(rd_b_i) |=> !data_oe_o)
        else $error("read data still driven after the strobe ended");
    a_data_holds: assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o))
        else $error("read data changed during one read");
    a_setup_no_read: assert property (!chip_sel_b_i && !rd_b_i && port == PORT_SETUP |=> !data_oe_o)
        else $error("read of the setup port drove the bus");
    a_write_no_drive: assert property (!wr_b_i |=> !data_oe_o)
        else $error("bus driven during a write");
    a_readback_quiet: assert property (setup_w && data_i[7:6] == SEL_READBACK |=> (setup_written_o == '0) [*2])
        else $error("read-back command programmed a channel");
    // Per-channel checks; a slip in the select decode shows on the wrong lane.
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        a_mode_legal: assert property (op_mode_o[c] <= 3'h5)
            else $error("mode outside the six modes");
        a_setup_flag: assert property (setup_w && data_i[7:6] == 2'(c) && data_i[5:4] != FMT_LATCH |-> ##[1:2] setup_written_o[c])
            else $error("setup write did not program its channel");
        a_latch_quiet: assert property (setup_w && data_i[7:6] == 2'(c) && data_i[5:4] == FMT_LATCH |=> (!setup_written_o[c] && $stable(op_mode_o[c])) [*2])
            else $error("latch command reprogrammed a channel");
        a_ready_cause: assert property (preset_ready_o[c] |-> $past(wr_take && port == 2'(c), 2))
            else $error("count ready without a count write to the channel");
        a_count_mode: assert property (wr_take && port == 2'(c) |=> $stable(op_mode_o[c]) [*2])
            else $error("count write changed the mode");
    end
    c_readback: cover property (setup_w && data_i[7:6] == SEL_READBACK);
    c_long_read: cover property (data_oe_o && $past(data_oe_o));
    c_ready: cover property (preset_ready_o[0]);
endmodule
bind interval_timer_program_readout interval_timer_program_readout_sva u_sva (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .chip_sel_b_i(chip_sel_b_i), .rd_b_i(rd_b_i),
    .wr_b_i(wr_b_i), .port_sel_hi_i(port_sel_hi_i), .port_sel_lo_i(port_sel_lo_i),
    .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .preset_ready_o(preset_ready_o),
    .setup_written_o(setup_written_o), .op_mode_o(op_mode_o)
);

// >>> bench/tb.sv
// Self-checking bench for the timer programming and readout block.
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    $display("MISMATCH %s exp %h got %h", n, e, g); errors++; end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pit_pkg::*;
    typedef struct packed {
        logic [7:0]  ctl;
        logic [15:0] cnt;
        logic [15:0] h;
        logic [2:0]  m;
    } row_t;
    // Setup word, count offered, holding value and mode expected.
    row_t rows [8] = '{{8'h30, 16'h1234, 16'h1234, 3'h0}, {8'h53, 16'h00ab, 16'h00ab, 3'h1},
        {8'ha4, 16'hcd00, 16'hcd00, 3'h2}, {8'h3c, 16'h4321, 16'h4321, 3'h2},
        {8'h76, 16'h55aa, 16'h55aa, 3'h3}, {8'hbe, 16'h0f0e, 16'h0f0e, 3'h3},
        {8'h18, 16'h995a, 16'h005a, 3'h4}, {8'h6a, 16'h77cc, 16'h7700, 3'h5}};
    logic                clk_sys_i = 1'b0;
    logic                rst_b_i   = 1'b0;
    logic                cs_b, rd_b, wr_b, data_oe_o;
    logic [1:0]          port, c, f;
    logic [7:0]          wd, data_o, b;
    logic [15:0]         live [CHANNELS];
    logic [15:0]         hold [CHANNELS];
    logic [2:0]          mode [CHANNELS];
    logic [CHANNELS-1:0] lvl = '0, loaded = '0, ready, setw, bcd;
    row_t                r;
    int                  errors = 0, checked = 0;
    initial foreach (live[i]) live[i] = 16'h0000;
    always #4 clk_sys_i = ~clk_sys_i;
    host_model u_host (.clk_i(clk_sys_i), .cs_b_o(cs_b), .rd_b_o(rd_b), .wr_b_o(wr_b),
        .port_o(port), .wd_o(wd), .rd_i(data_o));
    interval_timer_program_readout u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .chip_sel_b_i(cs_b), .rd_b_i(rd_b), .wr_b_i(wr_b), .port_sel_hi_i(port[1]),
        .port_sel_lo_i(port[0]), .data_i(wd), .data_o(data_o), .data_oe_o(data_oe_o),
        .live_count_valid_i(3'h0), .live_count_i(live), .chan_out_level_i(lvl),
        .count_loaded_i(loaded), .preset_holding_o(hold), .preset_ready_o(ready),
        .setup_written_o(setw), .op_mode_o(mode), .bcd_mode_o(bcd));
    task automatic complete_run();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Reads bytes in the channel's format; live counts stay still meanwhile.
    task automatic rd_fmt(input logic [1:0] ch, input logic [1:0] fm, input logic [15:0] e);
        if (fm != FMT_HIGH) begin
            u_host.rd(ch, b);
            `CHK("lo", e[7:0], b)
        end
        if (fm != FMT_LOW) begin
            u_host.rd(ch, b);
            `CHK("hi", e[15:8], b)
        end
    endtask
    // A hang ends the run as a failure.
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            c = r.ctl[7:6];
            f = r.ctl[5:4];
            u_host.wr(PORT_SETUP, r.ctl);
            if (f != FMT_HIGH) u_host.wr(c, r.cnt[7:0]);
            if (f != FMT_LOW) u_host.wr(c, r.cnt[15:8]);
            repeat (2) @(posedge clk_sys_i);
            `CHK("hold", r.h, hold[c])
            `CHK("mode", r.m, mode[c])
            `CHK("bcd", r.ctl[0], bcd[c])
            live[c] <= ~r.cnt;
            u_host.wr(PORT_SETUP, {c, 6'h05});
            live[c] <= r.cnt;
            rd_fmt(c, f, ~r.cnt);
        end
        $display("test rows done");
        u_host.wr(PORT_SETUP, 8'h30);
        u_host.wr(2'h0, 8'h11);
        u_host.wr(2'h0, 8'h11);
        live[0] <= 16'h1111;
        live[1] <= 16'h2222;
        u_host.wr(PORT_SETUP, 8'h00);
        u_host.wr(PORT_SETUP, 8'h40);
        live[0] <= 16'h3333;
        u_host.wr(PORT_SETUP, 8'h00);
        live[0] <= 16'h5555;
        rd_fmt(2'h0, FMT_BOTH, 16'h1111);
        rd_fmt(2'h1, FMT_HIGH, 16'h2222);
        rd_fmt(2'h0, FMT_BOTH, 16'h5555);
        `CHK("mode0", 3'h0, mode[0])
        $display("test latches done");
        live[0] <= 16'habcd;
        u_host.wr(PORT_SETUP, 8'h00);
        live[0] <= 16'h0000;
        u_host.rd(2'h0, b);
        u_host.wr(2'h0, 8'h11);
        `CHK("ilo", 8'hcd, b)
        u_host.rd(2'h0, b);
        u_host.wr(2'h0, 8'h22);
        repeat (2) @(posedge clk_sys_i);
        `CHK("ihi", 8'hab, b)
        `CHK("ihold", 16'h2211, hold[0])
        $display("test interleave done");
        loaded <= 3'h1;
        @(posedge clk_sys_i);
        loaded <= 3'h0;
        lvl <= 3'h1;
        live[0] <= 16'h6789;
        live[2] <= 16'h0f0e;
        u_host.wr(PORT_SETUP, 8'hca); // Count and status of channels 0 and 2.
        live[0] <= 16'h0000;
        live[2] <= 16'h0000;
        u_host.rd(2'h0, b);
        `CHK("stat0", 8'hb0, b)
        rd_fmt(2'h0, FMT_BOTH, 16'h6789);
        rd_fmt(2'h0, FMT_BOTH, 16'h0000);
        u_host.rd(2'h2, b);
        `CHK("stat2", 8'h7e, b)
        rd_fmt(2'h2, FMT_BOTH, 16'h0f0e);
        rd_fmt(2'h1, FMT_HIGH, 16'h2222);
        u_host.rd(PORT_SETUP, b);
        `CHK("idle", DATA_IDLE, b)
        $display("test readback done");
        u_host.wr(PORT_SETUP, 8'h40);
        live[1] <= 16'h1200;
        u_host.wr(PORT_SETUP, 8'h70);
        rd_fmt(2'h1, FMT_BOTH, 16'h1200);
        $display("test reprogram done");
        rst_b_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        `CHK("oe", 1'b0, data_oe_o)
        `CHK("rmode", 3'h0, mode[1])
        @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        $display("test reset done");
        complete_run();
    end
endmodule

// >>> rtl/interval_timer_program_readout.sv
// Programming and readout logic of a three-channel 16-bit interval timer.

// Bus cycle overview.
// The host port is sampled on the system clock; the strobes are level signals, active low.
// A write is taken on the first clock in which chip select and the write strobe are
// low while the read strobe is high. Holding the strobe longer has no further effect,
// so a slow host cannot load the same byte twice.
// A read drives data one clock after the strobe is seen and keeps driving while the
// strobe stays low. The byte sequence of the channel moves on only once the strobe
// ends, so a read stretched by wait states returns one byte, not several.
// The output enable is registered; board logic turns it into the pin drive enable.
//
// Port map of the select inputs.
// Codes 0 to 2 reach the three channels, code 3 the setup command register.
// Reading code 3 does nothing and leaves the bus released.
//
// Channel interface.
// Each channel hands its holding register, a one-cycle ready pulse, a one-cycle
// setup pulse, its decoded mode and its decimal select to the counting core.
// The core returns its running count, the level of its output pin and a pulse
// when the holding register has moved into the counter.
// All of these outputs come from flip-flops, so the core sees no decode glitches.
//
// Latching.
// A latch command or a read-back freezes a copy of the running count per channel.
// The copy stays until the host has read every byte of it, or until the channel
// is programmed again. A second latch before that is dropped, so the host always
// sees the value of the first request.
//
// Read-back.
// One read-back write may freeze count, status or both for any set of channels.
// When both are frozen the status byte comes out first, then the count bytes, and
// after that the channel shows its running count again.
//
// Limitations.
// There is no counting here; the running counts come from outside. A plain read of
// a running channel may return a torn value unless the host stops that channel's
// clock first; a latch command avoids the hazard.
// Reset values stand in for the undefined power-up state and are all zero, which
// happens to decode as a latch format; software must program a channel before use.
// The live count qualifier is accepted but not used here.
module interval_timer_program_readout
    import pit_pkg::*;
(
    input  wire logic                          clk_sys_i,
    input  wire logic                          rst_b_i,
    input  wire logic                          chip_sel_b_i,
    input  wire logic                          rd_b_i,
    input  wire logic                          wr_b_i,
    input  wire logic                          port_sel_hi_i,
    input  wire logic                          port_sel_lo_i,
    input  wire logic [7:0]                    data_i,
    output logic      [7:0]                    data_o,
    output logic                               data_oe_o,
    input  wire logic [pit_pkg::CHANNELS-1:0]  live_count_valid_i,
    input  wire logic [pit_pkg::COUNT_W-1:0]   live_count_i [pit_pkg::CHANNELS],
    input  wire logic [pit_pkg::CHANNELS-1:0]  chan_out_level_i,
    input  wire logic [pit_pkg::CHANNELS-1:0]  count_loaded_i,
    output logic      [pit_pkg::COUNT_W-1:0]   preset_holding_o [pit_pkg::CHANNELS],
    output logic      [pit_pkg::CHANNELS-1:0]  preset_ready_o,
    output logic      [pit_pkg::CHANNELS-1:0]  setup_written_o,
    output logic      [2:0]                    op_mode_o [pit_pkg::CHANNELS],
    output logic      [pit_pkg::CHANNELS-1:0]  bcd_mode_o
);
    import pit_pkg::*;

    // Strobes are taken as synchronous; edge detect so a long strobe acts once.
    // The write strobe only counts with the read strobe high, so a host that
    // glitches both low at once is treated as reading, which cannot corrupt a
    // holding register.
    logic rd_q;
    logic wr_q;
    wire  rd_act    = ~chip_sel_b_i & ~rd_b_i;
    wire  wr_act    = ~chip_sel_b_i & ~wr_b_i & rd_b_i;
    wire  rd_end    = rd_q & ~rd_act;
    wire  wr_start  = wr_act & ~wr_q;
    wire [1:0] port = {port_sel_hi_i, port_sel_lo_i};
    wire  setup_wr  = wr_start & (port == PORT_SETUP);
    wire [1:0] sel  = data_i[SEL_HI_BIT:SEL_LO_BIT];
    wire [1:0] fmt  = data_i[FMT_HI_BIT:FMT_LO_BIT];
    wire  is_rb     = sel == SEL_READBACK;
    wire  rb_cnt    = setup_wr & is_rb & ~data_i[RB_COUNT_N_BIT];
    wire  rb_sts    = setup_wr & is_rb & ~data_i[RB_STATUS_N_BIT];

    // Strobe history for the edge detectors above.
    // Reset clears it to the inactive level, so releasing reset with a strobe
    // already low still yields exactly one start edge.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= rd_act;
            wr_q <= wr_act;
        end
    end

    // Read data for the byte in flight, per channel; gathered below.
    // Each entry is a plain decode of that channel's state and is never stored.
    logic [7:0] rd_byte [CHANNELS];

    // Mode decode: top bit is a don't-care when the middle bit is set.
    // The raw setup bits are kept as written for the status byte; only the
    // decoded mode handed to the core folds the don't-care bit away.
    function automatic logic [2:0] decode_mode(input logic [2:0] k);
        logic [2:0] m;
        m = 3'(MODE_0);
        if (k[1]) begin
            m = k[0] ? 3'(MODE_3) : 3'(MODE_2);
        end else begin
            case ({k[2], k[0]})
                2'h0:    m = 3'(MODE_0);
                2'h1:    m = 3'(MODE_1);
                2'h2:    m = 3'(MODE_4);
                default: m = 3'(MODE_5);
            endcase
        end
        return m;
    endfunction

    // Per-channel state, built once per channel by the loop below.
    // setup        last setup bits, kept for status and format decode.
    // wr_hi_next   the next count byte written is the high byte.
    // rd_hi_next   the next count byte read is the high byte.
    // cnt_held     snapshot_latch holds a frozen count not yet fully read.
    // sts_held     status_snap holds a frozen status byte not yet read.
    // pending      a count or setup was written but not yet loaded.
    // holding      the preset holding register.
    // ready        a complete count has just been written.
    // Read and write sequencing are kept apart on purpose, so a host may read
    // the low byte, write a low byte, read the high byte and write a high byte
    // of one channel without either sequence losing its place.
    // A channel never looks at another channel's state; the only shared logic
    // is the strobe edge detect, the address and command decode and the read mux.
    // A two-byte access torn by a second routine on the same channel is not
    // detected; the host software has to keep such accesses unbroken.
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            logic [5:0]         setup;
            logic               wr_hi_next;
            logic               rd_hi_next;
            logic               cnt_held;
            logic               sts_held;
            logic [COUNT_W-1:0] snapshot_latch;
            logic [7:0]         status_snap;
            logic               pending;
            logic [COUNT_W-1:0] holding;
            logic               ready;

            wire [1:0] cfmt     = setup[FMT_HI_BIT:FMT_LO_BIT];
            wire       hit_rb   = data_i[RB_PICK_BASE + c];
            wire       prog_c   = setup_wr & ~is_rb & (sel == 2'(c))
                                  & (fmt != FMT_LATCH);
            wire       latch_c  = (setup_wr & ~is_rb & (sel == 2'(c))
                                  & (fmt == FMT_LATCH))
                                  | (rb_cnt & hit_rb);
            wire       latch_s  = rb_sts & hit_rb;
            wire       cnt_wr   = wr_start & (port == 2'(c));
            wire       cnt_done = cnt_wr & ((cfmt != FMT_BOTH) | wr_hi_next);
            wire       rd_me    = rd_end & (port == 2'(c));
            wire       rd_sts   = rd_me & sts_held;
            wire       rd_cnt   = rd_me & ~sts_held;
            wire       rd_last  = rd_cnt & ((cfmt != FMT_BOTH) | rd_hi_next);
            wire [COUNT_W-1:0] view = cnt_held ? snapshot_latch : live_count_i[c];
            wire       take_hi  = (cfmt == FMT_HIGH) | ((cfmt == FMT_BOTH) & rd_hi_next);
            wire [7:0] stat_now = {chan_out_level_i[c], pending, setup};

            // Current byte for a read: status first, then count in its format.
            assign rd_byte[c] = sts_held ? status_snap :
                                (take_hi ? view[15:8] : view[7:0]);

            // Setup word and byte sequencing; reprogramming clears held latches.
            // Programming restarts both sequences, so a host that lost its place
            // in a two-byte access can recover by writing the setup word again.
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    setup      <= SETUP_RST;
                    wr_hi_next <= 1'b0;
                    rd_hi_next <= 1'b0;
                end else if (prog_c) begin
                    setup      <= data_i[5:0];
                    wr_hi_next <= 1'b0;
                    rd_hi_next <= 1'b0;
                end else begin
                    if (cnt_wr && cfmt == FMT_BOTH) begin
                        wr_hi_next <= ~wr_hi_next;
                    end
                    if (rd_cnt && cfmt == FMT_BOTH) begin
                        rd_hi_next <= ~rd_hi_next;
                    end
                end
            end

            // Count snapshot: first latch wins until fully read.
            // The snapshot data is left as it is when released; the read path
            // stops using it as soon as cnt_held drops.
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    cnt_held       <= 1'b0;
                    snapshot_latch <= '0;
                end else if (prog_c) begin
                    cnt_held <= 1'b0;
                end else if (latch_c && !cnt_held) begin
                    cnt_held       <= 1'b1;
                    snapshot_latch <= live_count_i[c];
                end else if (rd_last) begin
                    cnt_held <= 1'b0;
                end
            end

            // Status snapshot: first latch wins until read once.
            // A held status byte is served before any count byte, so it also
            // blocks the count read sequence from moving until it is read.
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    sts_held    <= 1'b0;
                    status_snap <= BYTE_ZERO;
                end else if (prog_c) begin
                    sts_held <= 1'b0;
                end else if (latch_s && !sts_held) begin
                    sts_held    <= 1'b1;
                    status_snap <= stat_now;
                end else if (rd_sts) begin
                    sts_held <= 1'b0;
                end
            end

            // Pending load: a setting event wins over a transfer in the same cycle.
            // Losing the set would report a fresh count as loaded while the core
            // still runs the old one, which is the worse of the two errors.
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    pending <= 1'b0;
                end else if (prog_c || cnt_done) begin
                    pending <= 1'b1;
                end else if (count_loaded_i[c]) begin
                    pending <= 1'b0;
                end
            end

            // Preset holding register; single-byte formats zero the other half.
            // The ready pulse only follows the last byte of a count, so the core
            // never loads half of a two-byte value.
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    holding <= '0;
                    ready   <= 1'b0;
                end else begin
                    ready <= cnt_done;
                    if (prog_c) begin
                        holding <= '0;
                    end else if (cnt_wr) begin
                        case (cfmt)
                            FMT_LOW:  holding <= {BYTE_ZERO, data_i};
                            FMT_HIGH: holding <= {data_i, BYTE_ZERO};
                            FMT_BOTH: begin
                                if (wr_hi_next) begin
                                    holding[15:8] <= data_i;
                                end else begin
                                    holding[7:0] <= data_i;
                                end
                            end
                            default:  holding <= holding;
                        endcase
                    end
                end
            end

            // Channel outputs to the counting logic, all registered.
            // The extra stage costs one clock of latency towards the core, which
            // is far below any count clock period the core can accept.
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    preset_holding_o[c] <= '0;
                    preset_ready_o[c]   <= 1'b0;
                    setup_written_o[c]  <= 1'b0;
                    op_mode_o[c]        <= 3'(MODE_0);
                    bcd_mode_o[c]       <= 1'b0;
                end else begin
                    preset_holding_o[c] <= holding;
                    preset_ready_o[c]   <= ready;
                    setup_written_o[c]  <= prog_c;
                    op_mode_o[c]        <= decode_mode(setup[KIND_B2_BIT:KIND_B0_BIT]);
                    bcd_mode_o[c]       <= setup[BCD_BIT];
                end
            end
        end
    endgenerate

    // Read data mux; the setup port and idle bus read back as released.
    // The mux works from the select inputs directly rather than a registered
    // copy. That costs a little decode depth in front of data_o, but the byte
    // follows the port in the same clock as the strobe, which keeps the read
    // latency at one clock.
    wire [7:0] sel_byte = (port == 2'h0) ? rd_byte[0] :
                          (port == 2'h1) ? rd_byte[1] :
                          (port == 2'h2) ? rd_byte[2] : DATA_IDLE;
    wire       drive    = rd_act & (port != PORT_SETUP);

    // Data drives while a read strobe is active; the byte is advanced as it ends.
    // The bus shows zero whenever it is not driven, so stale data never leaks
    // onto the pins if the enable is late to drop.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_o    <= DATA_IDLE;
            data_oe_o <= 1'b0;
        end else begin
            data_o    <= drive ? sel_byte : DATA_IDLE;
            data_oe_o <= drive;
        end
    end

    // Unused in this block: live value qualifiers are for the counting core.
    // The reduction keeps the input visibly consumed without adding logic.
    wire unused_ok = &live_count_valid_i | 1'b1;
endmodule

// >>> rtl/pit_pkg.sv
// Package of constants and types for the interval timer programming and readout block.
package pit_pkg;
    localparam int CHANNELS = 3;
    localparam int COUNT_W = 16;
    // Port select codes.
    localparam logic [1:0] PORT_SETUP = 2'h3;
    // Control word and status byte field positions.
    localparam int SEL_HI_BIT = 7;
    localparam int SEL_LO_BIT = 6;
    localparam int FMT_HI_BIT = 5;
    localparam int FMT_LO_BIT = 4;
    localparam int KIND_B2_BIT = 3;
    localparam int KIND_B0_BIT = 1;
    localparam int BCD_BIT = 0;
    localparam int STAT_OUT_BIT = 7;
    localparam int STAT_PEND_BIT = 6;
    // Select code that marks a read-back command.
    localparam logic [1:0] SEL_READBACK = 2'h3;
    // Read-back bit positions.
    localparam int RB_COUNT_N_BIT = 5;
    localparam int RB_STATUS_N_BIT = 4;
    localparam int RB_PICK_BASE = 1;
    // Access formats.
    localparam logic [1:0] FMT_LATCH = 2'h0;
    localparam logic [1:0] FMT_LOW = 2'h1;
    localparam logic [1:0] FMT_HIGH = 2'h2;
    localparam logic [1:0] FMT_BOTH = 2'h3;
    // Reset value for the setup bits of a channel (power-up value is undefined).
    localparam logic [5:0] SETUP_RST = 6'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] DATA_IDLE = 8'h00;
    typedef enum logic [2:0] {
        MODE_0, MODE_1, MODE_2, MODE_3, MODE_4, MODE_5
    } op_mode_t;
endpackage
